// >>> src/cmd_interp.sv
// ASCII command interpreter: parses host lines and produces replies.
`timescale 1ns/1ps
`default_nettype none
// Function
// - E then CR empties the transmit FIFO and echoes E CR.
// - Standard request: t, three hex id digits up to 7FF, length, data, CR.
// - Extended request: T, eight hex id digits up to 1FFFFFFF, length, data.
// - Valid standard request queues an 11-bit frame and answers z CR.
// - Valid extended request queues a 29-bit frame and answers Z CR.
// - F returns the status byte as two hex characters and CR.
// - Status bit 0 is receive warning or transmit warning.
// - Status bit 1: receive error counter above 95, at most 127.
// - Status bit 2: transmit error counter above 95.
// - Status bit 3: receive counter above 127; red LED single-flashes.
// - Status bit 4: transmit counter above 127; red LED single-flashes.
// - Status bit 5: transmit counter above 255; red LED stays on.
// - Status bits 6 and 7 flag receive buffer one and zero overflow.
// - V returns V, two BCD hardware digits, two BCD firmware digits, CR.
// - N returns N, four serial characters, CR.
// - R answers CR and restarts the controller, keeping stored settings.
// - B enters the loader with message and prompt; only programming exits.
// - O opens the channel in normal mode for receive and transmit.
// - In listen-only mode transmit requests get an error reply.
module cmd_interp #(
  parameter logic [7:0]  HW_VER_BCD = 8'h10,
  parameter logic [7:0]  FW_VER_BCD = 8'h10,
  parameter logic [31:0] SERIAL_TXT = 32'h41303031,
  parameter int          FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  output logic             frm_valid,
  output logic             frm_ext,
  output logic      [28:0] frm_id,
  output logic      [3:0]  frm_len,
  output logic      [63:0] frm_data,
  input  wire logic        frm_ready,
  input  wire logic [8:0]  rx_err_cnt,
  input  wire logic [8:0]  tx_err_cnt,
  input  wire logic        rx1_ovf,
  input  wire logic        rx0_ovf,
  output logic             chan_open,
  output logic             chan_listen,
  output logic             ctrl_restart,
  output logic             boot_mode,
  output logic             led_red_on,
  output logic             led_red_flash
);
  // One FIFO word is the extended flag, 29 id bits, 4 length bits, 64 data.
  localparam int FW = 98;
  logic [7:0] rx1_q, rx2_q;
  logic       rxv1_q, rxv2_q;
  logic [7:0] line_q [cmd_pkg::REPLY_MAX];
  logic [4:0] llen_q;
  logic       ovr_q;
  logic       exec_q;
  logic [7:0] rep_q [cmd_pkg::REPLY_MAX];
  logic [4:0] rlen_q, ridx_q;
  logic       busy_q;
  cmd_pkg::chan_mode_t mode_q;
  logic       boot_q;
  logic       rst_q;
  logic [7:0] status;
  frame_if #(.W(FW)) fin ();
  frame_if #(.W(FW)) fout ();

  // Host bytes arrive from the serial bridge domain, so they are resynced.
  // A byte is consumed once; the source must drop valid after each byte.
  logic rxv3_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx1_q  <= 8'h00;
      rx2_q  <= 8'h00;
      rxv1_q <= 1'b0;
      rxv2_q <= 1'b0;
      rxv3_q <= 1'b0;
    end else if (ce) begin
      rx1_q  <= rx_data;
      rx2_q  <= rx1_q;
      rxv1_q <= rx_valid;
      rxv2_q <= rxv1_q;
      rxv3_q <= rxv2_q;
    end
  end
  wire rx_byte = rxv2_q && !rxv3_q && !busy_q && !exec_q && !boot_q;
  assign rx_ready = !busy_q && !exec_q && !boot_q;

  // Line decode on the buffered command.
  function automatic logic hexok(input logic [7:0] c);
    hexok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
            (c >= 8'h61 && c <= 8'h66);
  endfunction
  function automatic logic [3:0] hexv(input logic [7:0] c);
    if (c <= 8'h39) hexv = c[3:0];
    else hexv = 4'(c[3:0] + 4'h9);
  endfunction
  function automatic logic [7:0] tohex(input logic [3:0] n);
    tohex = (n < 4'ha) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
  endfunction

  wire [7:0] op  = line_q[0];
  wire       ext = (op == cmd_pkg::CH_EXT);
  wire [4:0] nid = ext ? 5'(cmd_pkg::EXT_ID_DIGITS)
                       : 5'(cmd_pkg::STD_ID_DIGITS);
  wire [7:0] lch = line_q[nid + 5'd1];
  wire [3:0] dlc = hexv(lch);
  logic        hex_all;
  logic [31:0] idv;
  logic [63:0] dat;
  always_comb begin
    hex_all = 1'b1;
    idv     = 32'h0;
    dat     = 64'h0;
    for (int i = 1; i < cmd_pkg::REPLY_MAX; i++) begin
      if (5'(i) < llen_q && !hexok(line_q[i])) hex_all = 1'b0;
    end
    for (int i = 0; i < cmd_pkg::EXT_ID_DIGITS; i++) begin
      if (5'(i) < nid) idv = {idv[27:0], hexv(line_q[i+1])};
    end
    for (int i = 0; i < cmd_pkg::MAX_LEN * 2; i++) begin
      if (i < 2 * int'(dlc)) dat[63-4*i -: 4] = hexv(line_q[int'(nid)+2+i]);
    end
  end
  wire len_ok = (lch >= 8'h30) && (lch <= 8'h38);
  wire len_match = (llen_q == 5'(nid + 5'd2 + 5'(2 * dlc)));
  wire id_ok = ext ? (idv[28:0] <= cmd_pkg::EXT_ID_MAX && idv[31:29] == 3'h0)
                   : (idv[10:0] <= cmd_pkg::STD_ID_MAX && idv[31:11] == '0);
  wire tx_cmd = (op == cmd_pkg::CH_STD) || ext;
  wire tx_good = tx_cmd && !ovr_q && len_ok && len_match && hex_all && id_ok;
  wire tx_go = tx_good && mode_q == cmd_pkg::CH_NORMAL && fin.ready;
  wire bare = (llen_q == 5'd1) && !ovr_q;
  wire do_flush = exec_q && bare && op == cmd_pkg::CH_FLUSH;

  assign fin.valid = exec_q && tx_go;
  assign fin.data  = {ext, idv[28:0], dlc, dat};
  frame_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .flush (do_flush),
    .wr    (fin),
    .rd    (fout)
  );
  assign frm_valid = fout.valid;
  assign {frm_ext, frm_id, frm_len, frm_data} = fout.data;
  assign fout.ready = frm_ready;

  status_enc u_stat (
    .rx_err_cnt (rx_err_cnt),
    .tx_err_cnt (tx_err_cnt),
    .rx1_ovf    (rx1_ovf),
    .rx0_ovf    (rx0_ovf),
    .status     (status)
  );
  assign led_red_on    = status[cmd_pkg::ST_BOFF];
  assign led_red_flash = !status[cmd_pkg::ST_BOFF] &&
                         (status[cmd_pkg::ST_RXP] || status[cmd_pkg::ST_TXP]);

  // Line assembly; an overlong line is remembered and refused at CR.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      llen_q <= 5'd0;
      ovr_q  <= 1'b0;
      exec_q <= 1'b0;
    end else if (ce) begin
      exec_q <= 1'b0;
      if (exec_q) begin
        llen_q <= 5'd0;
        ovr_q  <= 1'b0;
      end else if (rx_byte) begin
        if (rx2_q == cmd_pkg::CH_CR) exec_q <= 1'b1;
        else if (llen_q == 5'(cmd_pkg::REPLY_MAX - 1)) ovr_q <= 1'b1;
        else llen_q <= llen_q + 5'd1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (ce && rx_byte && rx2_q != cmd_pkg::CH_CR) line_q[llen_q] <= rx2_q;
  end

  // Reply text selection.
  logic [7:0] r [cmd_pkg::REPLY_MAX];
  logic [4:0] rl;
  logic [7:0] boot_txt [23];
  assign boot_txt = '{8'h45, 8'h6e, 8'h74, 8'h65, 8'h72, 8'h69, 8'h6e, 8'h67,
                      8'h20, 8'h42, 8'h6f, 8'h6f, 8'h74, 8'h2e, 8'h2e, 8'h2e,
                      8'h0d, 8'h42, 8'h6f, 8'h6f, 8'h74, 8'h3a, 8'h3e};
  always_comb begin
    for (int i = 0; i < cmd_pkg::REPLY_MAX; i++) r[i] = cmd_pkg::CH_CR;
    rl = 5'd1;
    r[0] = cmd_pkg::CH_BELL;
    if (tx_cmd && !bare) begin
      if (tx_go) begin
        r[0] = ext ? cmd_pkg::CH_ACK_E : cmd_pkg::CH_ACK_S;
        rl = 5'd2;
      end
    end else if (bare) begin
      unique case (op)
        cmd_pkg::CH_FLUSH: begin
          r[0] = cmd_pkg::CH_FLUSH;
          rl = 5'd2;
        end
        cmd_pkg::CH_STAT: begin
          r[0] = tohex(status[7:4]);
          r[1] = tohex(status[3:0]);
          rl = 5'd3;
        end
        cmd_pkg::CH_VER: begin
          r[0] = cmd_pkg::CH_VER;
          r[1] = tohex(HW_VER_BCD[7:4]);
          r[2] = tohex(HW_VER_BCD[3:0]);
          r[3] = tohex(FW_VER_BCD[7:4]);
          r[4] = tohex(FW_VER_BCD[3:0]);
          rl = 5'd6;
        end
        cmd_pkg::CH_SER: begin
          r[0] = cmd_pkg::CH_SER;
          r[1] = SERIAL_TXT[31:24];
          r[2] = SERIAL_TXT[23:16];
          r[3] = SERIAL_TXT[15:8];
          r[4] = SERIAL_TXT[7:0];
          rl = 5'd6;
        end
        cmd_pkg::CH_BOOT: begin
          for (int i = 0; i < 23; i++) r[i] = boot_txt[i];
          rl = cmd_pkg::BOOT_MSG_LEN;
        end
        cmd_pkg::CH_RST, cmd_pkg::CH_CLOSE, cmd_pkg::CH_OPEN,
        cmd_pkg::CH_LSTN: begin
          r[0] = cmd_pkg::CH_CR;
        end
        default: r[0] = cmd_pkg::CH_BELL;
      endcase
    end
  end

  // Reply shifter and mode state.
  always_ff @(posedge clk) begin
    if (ce && exec_q) begin
      for (int i = 0; i < cmd_pkg::REPLY_MAX; i++) rep_q[i] <= r[i];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rlen_q <= 5'd0;
      ridx_q <= 5'd0;
      busy_q <= 1'b0;
      mode_q <= cmd_pkg::CH_CLOSED;
      boot_q <= 1'b0;
      rst_q  <= 1'b0;
    end else if (ce) begin
      rst_q <= 1'b0;
      if (exec_q) begin
        rlen_q <= rl;
        ridx_q <= 5'd0;
        busy_q <= 1'b1;
        if (bare && op == cmd_pkg::CH_OPEN) mode_q <= cmd_pkg::CH_NORMAL;
        if (bare && op == cmd_pkg::CH_LSTN) mode_q <= cmd_pkg::CH_LISTEN;
        if (bare && op == cmd_pkg::CH_CLOSE) mode_q <= cmd_pkg::CH_CLOSED;
        if (bare && op == cmd_pkg::CH_BOOT) boot_q <= 1'b1;
      end else if (busy_q && tx_ready) begin
        ridx_q <= ridx_q + 5'd1;
        if (ridx_q + 5'd1 == rlen_q) begin
          busy_q <= 1'b0;
          if (rep_q[0] == cmd_pkg::CH_CR && rlen_q == 5'd1 &&
              op == cmd_pkg::CH_RST) begin
            rst_q  <= 1'b1;
            mode_q <= cmd_pkg::CH_CLOSED;
          end
        end
      end
    end
  end
  assign tx_valid     = busy_q;
  assign tx_data      = rep_q[ridx_q];
  assign chan_open    = mode_q != cmd_pkg::CH_CLOSED;
  assign chan_listen  = mode_q == cmd_pkg::CH_LISTEN;
  assign ctrl_restart = rst_q;
  assign boot_mode    = boot_q;
endmodule
`default_nettype wire

// >>> src/cmd_pkg.sv
// Constants and types shared by the ASCII command interpreter.
package cmd_pkg;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_BELL  = 8'h07;
  localparam logic [7:0] CH_FLUSH = 8'h45;
  localparam logic [7:0] CH_STD   = 8'h74;
  localparam logic [7:0] CH_EXT   = 8'h54;
  localparam logic [7:0] CH_ACK_S = 8'h7a;
  localparam logic [7:0] CH_ACK_E = 8'h5a;
  localparam logic [7:0] CH_STAT  = 8'h46;
  localparam logic [7:0] CH_VER   = 8'h56;
  localparam logic [7:0] CH_SER   = 8'h4e;
  localparam logic [7:0] CH_RST   = 8'h52;
  localparam logic [7:0] CH_BOOT  = 8'h42;
  localparam logic [7:0] CH_OPEN  = 8'h4f;
  localparam logic [7:0] CH_LSTN  = 8'h4c;
  localparam logic [7:0] CH_CLOSE = 8'h43;
  localparam int STD_ID_DIGITS    = 3;
  localparam int EXT_ID_DIGITS    = 8;
  localparam int MAX_LEN          = 8;
  localparam logic [10:0] STD_ID_MAX = 11'h7ff;
  localparam logic [28:0] EXT_ID_MAX = 29'h1fffffff;
  localparam logic [8:0] WARN_LIMIT    = 9'h05f;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0ff;
  localparam int ST_WARN = 0;
  localparam int ST_RXW  = 1;
  localparam int ST_TXW  = 2;
  localparam int ST_RXP  = 3;
  localparam int ST_TXP  = 4;
  localparam int ST_BOFF = 5;
  localparam int ST_OVF1 = 6;
  localparam int ST_OVF0 = 7;
  localparam int REPLY_MAX = 32;
  localparam logic [4:0] BOOT_MSG_LEN = 5'd23;
  typedef enum logic [1:0] {CH_CLOSED, CH_NORMAL, CH_LISTEN} chan_mode_t;
endpackage

// >>> src/frame_if.sv
// Transmit frame path between the interpreter, its FIFO and the controller.
`timescale 1ns/1ps
`default_nettype none
interface frame_if #(parameter int W = 98);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> src/frame_fifo.sv
// Synchronous FIFO of frames with flush and back-pressure.
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 98,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic flush,
  frame_if.sink     wr,
  frame_if.src      rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire push = wr.valid && wr.ready;
  wire pop  = rd.valid && rd.ready;
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH)) && !flush;
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= wr.data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end else begin
        if (push) wp_q <= wp_q + 1'b1;
        if (pop) rp_q <= rp_q + 1'b1;
        cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/status_enc.sv
// Encodes the error counters and overflow flags into the status byte.
`timescale 1ns/1ps
`default_nettype none
module status_enc (
  input  wire logic [8:0] rx_err_cnt,
  input  wire logic [8:0] tx_err_cnt,
  input  wire logic       rx1_ovf,
  input  wire logic       rx0_ovf,
  output logic      [7:0] status
);
  wire rxw = (rx_err_cnt > cmd_pkg::WARN_LIMIT) &&
             (rx_err_cnt <= cmd_pkg::PASSIVE_LIMIT);
  wire txw = tx_err_cnt > cmd_pkg::WARN_LIMIT;
  assign status[cmd_pkg::ST_RXW]  = rxw;
  assign status[cmd_pkg::ST_TXW]  = txw;
  assign status[cmd_pkg::ST_WARN] = rxw | txw;
  assign status[cmd_pkg::ST_RXP]  = rx_err_cnt > cmd_pkg::PASSIVE_LIMIT;
  assign status[cmd_pkg::ST_TXP]  = tx_err_cnt > cmd_pkg::PASSIVE_LIMIT;
  assign status[cmd_pkg::ST_BOFF] = tx_err_cnt > cmd_pkg::BUSOFF_LIMIT;
  assign status[cmd_pkg::ST_OVF1] = rx1_ovf;
  assign status[cmd_pkg::ST_OVF0] = rx0_ovf;
endmodule
`default_nettype wire

// >>> test/ascii_can_command_interpreter_properties.sv
// Concurrent checks on the ports of the command interpreter.
`timescale 1ns/1ps
`default_nettype none
module cmd_interp_properties (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        frm_valid,
  input wire logic        frm_ext,
  input wire logic [28:0] frm_id,
  input wire logic [3:0]  frm_len,
  input wire logic        frm_ready,
  input wire logic [8:0]  rx_err_cnt,
  input wire logic [8:0]  tx_err_cnt,
  input wire logic        chan_open,
  input wire logic        chan_listen,
  input wire logic        ctrl_restart,
  input wire logic        boot_mode,
  input wire logic        led_red_on,
  input wire logic        led_red_flash
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // The lamps may be registered, so they are judged after settled counts.
  a_busoff_led: assert property ($stable(tx_err_cnt) [*3] |->
    led_red_on == (tx_err_cnt > 9'h0ff)) else $error("bus-off lamp wrong");
  a_passive_flash: assert property (
    $stable({rx_err_cnt, tx_err_cnt}) [*3] |-> led_red_flash ==
    ((rx_err_cnt > 9'h07f || tx_err_cnt > 9'h07f) && tx_err_cnt <= 9'h0ff))
    else $error("passive lamp wrong");
  a_reply_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte dropped");
  a_frame_hold: assert property (frm_valid && !frm_ready ##1 frm_valid
    |-> $stable({frm_ext, frm_id, frm_len})) else $error("frame changed");
  a_std_range: assert property (frm_valid && !frm_ext |->
    frm_id[28:11] == 18'h00000) else $error("standard id too wide");
  a_len_max: assert property (frm_valid |-> frm_len <= 4'h8)
    else $error("frame length above eight");
  a_restart_pulse: assert property ($rose(ctrl_restart) |=>
    !ctrl_restart) else $error("restart pulse too long");
  a_boot_sticky: assert property (boot_mode |=> boot_mode)
    else $error("loader mode left");
  a_listen_open: assert property (chan_listen |-> chan_open)
    else $error("listen mode on a closed channel");
  cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
  cover property (frm_valid && frm_ready && frm_ext);
  cover property ($rose(ctrl_restart));
endmodule
bind cmd_interp cmd_interp_properties chk (.clk, .nrst, .tx_valid,
  .tx_data, .tx_ready, .frm_valid, .frm_ext, .frm_id, .frm_len, .frm_ready,
  .rx_err_cnt, .tx_err_cnt, .chan_open, .chan_listen, .ctrl_restart,
  .boot_mode, .led_red_on, .led_red_flash);
`default_nettype wire

// >>> test/host_model.sv
// Host application model: sends command lines and gathers reply bytes.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            tx_ready
);
  logic [7:0] rq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  // A stalling host is ready for a reply byte only on every other cycle.
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk) if (tx_valid && tx_ready) rq.push_back(tx_data);
  // The line is synchronised on entry, so a byte is held five cycles and
  // dropped for three; the data is scrambled while nothing is offered.
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    while (rx_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    rx_data  = b;
    rx_valid = 1'b1;
    repeat (5) @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~b;
    repeat (3) @(negedge clk);
  endtask
  task automatic send(input string s);
    foreach (s[i]) put(s[i]);
    put(cmd_pkg::CH_CR);
  endtask
endmodule
`default_nettype wire

// >>> test/ascii_can_command_interpreter_tb.sv
// Self-checking bench for the ASCII command interpreter.
`timescale 1ns/1ps
`default_nettype none
module ascii_can_command_interpreter_tb;
  typedef struct {
    logic [8:0] rx;
    logic [8:0] tx;
    logic [1:0] ovf;
    logic [7:0] st;
  } row_t;
  localparam string CR  = "\015";
  localparam string ERR = "\007";
  row_t rows [9] = '{'{9'h000, 9'h000, 2'h0, 8'h00},
    '{9'h060, 9'h000, 2'h0, 8'h03}, '{9'h05f, 9'h05f, 2'h0, 8'h00},
    '{9'h07f, 9'h060, 2'h0, 8'h07}, '{9'h080, 9'h000, 2'h0, 8'h08},
    '{9'h000, 9'h080, 2'h0, 8'h15}, '{9'h000, 9'h100, 2'h0, 8'h35},
    '{9'h000, 9'h000, 2'h2, 8'h40}, '{9'h000, 9'h000, 2'h1, 8'h80}};
  string bad [5] = '{"t8000", "T200000000", "tXY10", "t4561", "t4562AB"};
  logic        clk = 1'b0, nrst = 1'b0, slow = 1'b0, frm_ready = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, frm_valid, frm_ext;
  logic        rx1_ovf, rx0_ovf, chan_open, chan_listen, ctrl_restart;
  logic        boot_mode, led_red_on, led_red_flash;
  logic [7:0]  rx_data, tx_data;
  logic [8:0]  rx_err_cnt, tx_err_cnt;
  logic [28:0] frm_id;
  logic [3:0]  frm_len;
  logic [63:0] frm_data;
  logic [97:0] last;
  int          err_count = 0, tests_run = 0, fcnt = 0, rcnt = 0;
  always #2.5 clk = ~clk;
  host_model host (.clk, .rx_ready, .tx_valid, .tx_data, .slow, .rx_valid,
    .rx_data, .tx_ready);
  cmd_interp uut (.clk, .nrst, .ce(1'b1), .rx_valid, .rx_data, .rx_ready,
    .tx_valid, .tx_data, .tx_ready, .frm_valid, .frm_ext, .frm_id, .frm_len,
    .frm_data, .frm_ready, .rx_err_cnt, .tx_err_cnt, .rx1_ovf, .rx0_ovf,
    .chan_open, .chan_listen, .ctrl_restart, .boot_mode, .led_red_on,
    .led_red_flash);
  always @(posedge clk) begin
    if (frm_valid && frm_ready) begin
      last <= {frm_ext, frm_id, frm_len, frm_data};
      fcnt <= fcnt + 1;
    end
    if (ctrl_restart === 1'b1) rcnt <= rcnt + 1;
  end
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // Status digits may come in either letter case, so those are folded.
  task automatic cmd(input string s, input string exp, input bit ci = 0);
    int n;
    string got;
    n = 0;
    got = "";
    host.rq.delete();
    host.send(s);
    while (host.rq.size() < exp.len() && n < 3000) begin
      @(negedge clk);
      n++;
    end
    repeat (20) @(negedge clk);
    foreach (host.rq[i]) got = {got, string'(host.rq[i])};
    check(ci ? got.toupper() == exp : got == exp, {"reply to ", s});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #450us;
    err_count++;
    end_of_test();
  end
  initial begin
    {rx_err_cnt, tx_err_cnt, rx1_ovf, rx0_ovf} = 20'h00000;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    foreach (rows[i]) begin
      {rx_err_cnt, tx_err_cnt} = {rows[i].rx, rows[i].tx};
      {rx1_ovf, rx0_ovf} = rows[i].ovf;
      cmd("F", $sformatf("%02X\015", rows[i].st), 1);
    end
    cmd("V", {"V1010", CR});
    cmd("N", {"NA001", CR});
    cmd("t4560", ERR);
    cmd("O", CR);
    cmd("E", {"E", CR});
    frm_ready = 1'b1;
    cmd("t34580123456789ABCDEF", {"z", CR});
    check(last === {1'b0, 29'h345, 4'h8, 64'h0123456789abcdef}, "std");
    cmd("T1FFFFFFF80123456789ABCDEF", {"Z", CR});
    check(last === {1'b1, 29'h1fffffff, 4'h8, 64'h0123456789abcdef}, "ext");
    cmd("t7FF0", {"z", CR});
    check(last[97:64] === {1'b0, 29'h7ff, 4'h0}, "std top id");
    foreach (bad[i]) cmd(bad[i], ERR);
    check(fcnt == 3, "frame sent on bad line");
    frm_ready = 1'b0;
    slow = 1'b1;
    repeat (16) cmd("t1230", {"z", CR});
    cmd("t1230", ERR);
    cmd("E", {"E", CR});
    check(frm_valid === 1'b0 && fcnt == 3, "flush left frames");
    slow = 1'b0;
    frm_ready = 1'b1;
    cmd("C", CR);
    cmd("L", CR);
    cmd("t1230", ERR);
    check(chan_listen === 1'b1 && fcnt == 3, "listen sent");
    cmd("R", CR);
    check(rcnt == 1 && chan_listen === 1'b0, "restart");
    host.rq.delete();
    host.send("B");
    repeat (400) @(negedge clk);
    check(boot_mode === 1'b1 &&
          host.rq.size() == int'(cmd_pkg::BOOT_MSG_LEN), "loader");
    cmd("V", "");
    end_of_test();
  end
endmodule
`default_nettype wire
